// ===== rtl/fmac_regs.sv
// Fault interrupt mask registers and ADC control register with interrupt gating.
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - Battery current regulation change pulses unless bit7 set.
// - Input bus over-voltage entry interrupts unless masked.
// - Battery over-voltage entry interrupts unless masked.
// - Input over-current fault interrupts unless masked.
// - Battery over-current fault interrupts unless masked.
// - Converter over-current fault interrupts unless masked.
// - Second input over-voltage entry interrupts unless masked.
// - First input over-voltage entry interrupts unless masked.
// - System short fault interrupts unless masked.
// - System over-voltage fault interrupts unless masked.
// - Reverse output over-voltage interrupts unless masked.
// - Reverse output under-voltage interrupts unless masked.
// - Thermal shutdown interrupts unless masked; reserved bits zero.
// - ADC enable bit, reset value zero.
// - Rate bit: continuous or one-shot conversion.
// - Speed field selects resolution 15 to 12.
// - Select single result or running average.
// - Select average seed: held or fresh.
// - Conversion-done interrupt only in one-shot mode.
module fmac_regs
  import fmac_pkg::*;
#(
  parameter int EVENT_COUNT = 13
) (
  // Clock and reset.
  input  wire logic             mclk_i,
  input  wire logic             reset_n_i,
  // Extra register resets: register-reset command and watchdog expiry.
  input  wire logic             reg_reset_i,
  input  wire logic             watchdog_reset_i,
  // Register access from the serial interface.
  input  wire fmac_reg_req_type reg_req_i,
  output logic [7:0]            reg_rdata_o,
  output logic                  reg_hit_o,
  // Fault event pulses from the detectors.
  input  wire logic             batt_cur_reg_change_i,
  input  wire logic             in_bus_ovp_enter_i,
  input  wire logic             batt_ovp_enter_i,
  input  wire logic             in_ocp_fault_i,
  input  wire logic             batt_ocp_fault_i,
  input  wire logic             conv_ocp_fault_i,
  input  wire logic             in2_ovp_enter_i,
  input  wire logic             in1_ovp_enter_i,
  input  wire logic             sys_short_fault_i,
  input  wire logic             sys_ovp_fault_i,
  input  wire logic             rev_ovp_fault_i,
  input  wire logic             rev_uvp_fault_i,
  input  wire logic             tshut_event_i,
  // ADC conversion-done event and its mask, held elsewhere.
  input  wire logic             adc_done_i,
  input  wire logic             adc_done_irq_block_i,
  // Decoded ADC settings and the interrupt pulse.
  output fmac_adc_cfg_type      adc_cfg_o,
  output logic                  irq_pulse_o,
  // Unmasked event copy so detection status is never hidden by masks.
  output logic [12:0]           fault_event_o
);

  // The event vector is fixed by the two mask registers; refuse other sizes.
  if (EVENT_COUNT != 13) begin : g_bad_count
    $error("EVENT_COUNT must be 13");
  end

  // Register storage.
  logic [7:0] mask_a_q;
  logic [7:0] mask_a_d;
  logic [7:0] mask_b_q;
  logic [7:0] mask_b_d;
  logic [7:0] adc_ctrl_q;
  logic [7:0] adc_ctrl_d;
  logic       irq_q;
  logic       irq_d;

  // Write strobes decoded from the address.
  wire        wr_a   = reg_req_i.wr && (reg_req_i.addr == FMAC_OFS_MASK_A);
  wire        wr_b   = reg_req_i.wr && (reg_req_i.addr == FMAC_OFS_MASK_B);
  wire        wr_adc = reg_req_i.wr && (reg_req_i.addr == FMAC_OFS_ADC_CTRL);

  // Named fields of the first mask register.
  wire batt_current_reg_irq_block      = mask_a_q[FMAC_BIT_BATT_CUR_REG];
  wire input_bus_overvolt_irq_block    = mask_a_q[FMAC_BIT_IN_BUS_OVP];
  wire battery_overvolt_irq_block      = mask_a_q[FMAC_BIT_BATT_OVP];
  wire input_overcurrent_irq_block     = mask_a_q[FMAC_BIT_IN_OCP];
  wire battery_overcurrent_irq_block   = mask_a_q[FMAC_BIT_BATT_OCP];
  wire converter_overcurrent_irq_block = mask_a_q[FMAC_BIT_CONV_OCP];
  wire second_input_overvolt_irq_block = mask_a_q[FMAC_BIT_IN2_OVP];
  wire first_input_overvolt_irq_block  = mask_a_q[FMAC_BIT_IN1_OVP];

  // Named fields of the second mask register.
  wire system_short_irq_block          = mask_b_q[FMAC_BIT_SYS_SHORT];
  wire system_overvolt_irq_block       = mask_b_q[FMAC_BIT_SYS_OVP];
  wire reverse_out_overvolt_irq_block  = mask_b_q[FMAC_BIT_REV_OVP];
  wire reverse_out_undervolt_irq_block = mask_b_q[FMAC_BIT_REV_UVP];
  wire thermal_shutdown_irq_block      = mask_b_q[FMAC_BIT_TSHUT];

  // Named fields of the ADC control register.
  wire       adc_enable             = adc_ctrl_q[FMAC_BIT_ADC_ENABLE];
  wire       adc_one_shot           = adc_ctrl_q[FMAC_BIT_ONE_SHOT];
  wire [1:0] adc_speed              = adc_ctrl_q[FMAC_BIT_SPEED_HI:FMAC_BIT_SPEED_LO];
  wire       running_average_select = adc_ctrl_q[FMAC_BIT_RUN_AVG];
  wire       average_seed_select    = adc_ctrl_q[FMAC_BIT_AVG_SEED];

  // Each event passes only while its block bit is clear.
  wire g_r1  = batt_cur_reg_change_i & ~batt_current_reg_irq_block;
  wire g_r2  = in_bus_ovp_enter_i    & ~input_bus_overvolt_irq_block;
  wire g_r3  = batt_ovp_enter_i      & ~battery_overvolt_irq_block;
  wire g_r4  = in_ocp_fault_i        & ~input_overcurrent_irq_block;
  wire g_r5  = batt_ocp_fault_i      & ~battery_overcurrent_irq_block;
  wire g_r6  = conv_ocp_fault_i      & ~converter_overcurrent_irq_block;
  wire g_r7  = in2_ovp_enter_i       & ~second_input_overvolt_irq_block;
  wire g_r8  = in1_ovp_enter_i       & ~first_input_overvolt_irq_block;
  wire g_r9  = sys_short_fault_i     & ~system_short_irq_block;
  wire g_r10 = sys_ovp_fault_i       & ~system_overvolt_irq_block;
  wire g_r11 = rev_ovp_fault_i       & ~reverse_out_overvolt_irq_block;
  wire g_r12 = rev_uvp_fault_i       & ~reverse_out_undervolt_irq_block;
  wire g_r13 = tshut_event_i         & ~thermal_shutdown_irq_block;

  // Conversion-done counts only in one-shot mode with the ADC enabled.
  wire g_done = adc_done_i & adc_enable & adc_one_shot & ~adc_done_irq_block_i;

  // Any unmasked event requests one interrupt pulse.
  wire any_event = g_r1 | g_r2 | g_r3 | g_r4 | g_r5 | g_r6 | g_r7 | g_r8 | g_r9 | g_r10
                 | g_r11 | g_r12 | g_r13 | g_done;

  // Read data selection; unmapped offsets read zero.
  wire        hit_any = (reg_req_i.addr == FMAC_OFS_MASK_A) || (reg_req_i.addr == FMAC_OFS_MASK_B)
                     || (reg_req_i.addr == FMAC_OFS_ADC_CTRL);
  wire [7:0]  rd_sel  = (reg_req_i.addr == FMAC_OFS_MASK_A)   ? mask_a_q :
                        (reg_req_i.addr == FMAC_OFS_MASK_B)   ? mask_b_q :
                        (reg_req_i.addr == FMAC_OFS_ADC_CTRL) ? adc_ctrl_q : 8'h00;

  // Next-state logic: register resets win over writes.
  always_comb begin
    mask_a_d   = mask_a_q;
    mask_b_d   = mask_b_q;
    adc_ctrl_d = adc_ctrl_q;
    if (wr_a) begin
      mask_a_d = reg_req_i.wdata;
    end
    if (wr_b) begin
      mask_b_d = reg_req_i.wdata & FMAC_WMASK_MASK_B;
    end
    if (wr_adc) begin
      adc_ctrl_d = reg_req_i.wdata;
    end
    if (watchdog_reset_i) begin
      // Watchdog expiry only turns the ADC off; other fields hold.
      adc_ctrl_d[FMAC_BIT_ADC_ENABLE] = 1'b0;
    end
    if (reg_reset_i) begin
      mask_a_d   = FMAC_RST_MASK_A;
      mask_b_d   = FMAC_RST_MASK_B;
      adc_ctrl_d = FMAC_RST_ADC_CTRL;
    end
    irq_d = any_event;
  end

  // Register update; the pulse is registered, so it follows the gated events one cycle later.
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      mask_a_q   <= FMAC_RST_MASK_A;
      mask_b_q   <= FMAC_RST_MASK_B;
      adc_ctrl_q <= FMAC_RST_ADC_CTRL;
      irq_q      <= 1'b0;
      reg_rdata_o <= 8'h00;
    end else begin
      mask_a_q   <= mask_a_d;
      mask_b_q   <= mask_b_d;
      adc_ctrl_q <= adc_ctrl_d;
      irq_q      <= irq_d;
      reg_rdata_o <= reg_req_i.rd ? rd_sel : 8'h00;
    end
  end

  // Handshake and decoded outputs.
  assign reg_hit_o   = (reg_req_i.rd || reg_req_i.wr) && hit_any;
  assign irq_pulse_o = irq_q;

  // Decoded ADC configuration; resolution is 15 minus the speed code.
  assign adc_cfg_o.enable          = adc_enable;
  assign adc_cfg_o.one_shot        = adc_one_shot;
  assign adc_cfg_o.speed           = adc_speed;
  assign adc_cfg_o.resolution      = FMAC_RES_BASE - {2'b00, adc_speed};
  assign adc_cfg_o.running_average = running_average_select;
  assign adc_cfg_o.average_seed    = average_seed_select;

  // Detection is passed on untouched by any mask.
  assign fault_event_o = {batt_cur_reg_change_i, in_bus_ovp_enter_i, batt_ovp_enter_i, in_ocp_fault_i,
                          batt_ocp_fault_i, conv_ocp_fault_i, in2_ovp_enter_i, in1_ovp_enter_i,
                          sys_short_fault_i, sys_ovp_fault_i, rev_ovp_fault_i, rev_uvp_fault_i,
                          tshut_event_i};

endmodule

`default_nettype wire

// ===== rtl/fmac_pkg.sv
// Package for the fault mask and ADC control register bank.
package fmac_pkg;

  // Register offsets within the charger register map.
  localparam logic [7:0] FMAC_OFS_MASK_A   = 8'h2C;
  localparam logic [7:0] FMAC_OFS_MASK_B   = 8'h2D;
  localparam logic [7:0] FMAC_OFS_ADC_CTRL = 8'h2E;

  // Values after reset.
  localparam logic [7:0] FMAC_RST_MASK_A   = 8'h00;
  localparam logic [7:0] FMAC_RST_MASK_B   = 8'h00;
  localparam logic [7:0] FMAC_RST_ADC_CTRL = 8'h30;

  // Writable bits of the second mask register; bits 1 and 0 are reserved and read zero.
  localparam logic [7:0] FMAC_WMASK_MASK_B = 8'hFC;

  // Field positions in the first fault mask register.
  localparam int FMAC_BIT_BATT_CUR_REG = 7;
  localparam int FMAC_BIT_IN_BUS_OVP   = 6;
  localparam int FMAC_BIT_BATT_OVP     = 5;
  localparam int FMAC_BIT_IN_OCP       = 4;
  localparam int FMAC_BIT_BATT_OCP     = 3;
  localparam int FMAC_BIT_CONV_OCP     = 2;
  localparam int FMAC_BIT_IN2_OVP      = 1;
  localparam int FMAC_BIT_IN1_OVP      = 0;

  // Field positions in the second fault mask register.
  localparam int FMAC_BIT_SYS_SHORT    = 7;
  localparam int FMAC_BIT_SYS_OVP      = 6;
  localparam int FMAC_BIT_REV_OVP      = 5;
  localparam int FMAC_BIT_REV_UVP      = 4;
  localparam int FMAC_BIT_TSHUT        = 2;

  // Field positions in the ADC control register.
  localparam int FMAC_BIT_ADC_ENABLE   = 7;
  localparam int FMAC_BIT_ONE_SHOT     = 6;
  localparam int FMAC_BIT_SPEED_HI     = 5;
  localparam int FMAC_BIT_SPEED_LO     = 4;
  localparam int FMAC_BIT_RUN_AVG      = 3;
  localparam int FMAC_BIT_AVG_SEED     = 2;

  // Effective resolution for speed code zero; each step up drops one bit.
  localparam logic [3:0] FMAC_RES_BASE = 4'hF;

  // Register access strobe bundle from the serial interface.
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } fmac_reg_req_type;

  // Decoded ADC settings handed to the converter.
  typedef struct packed {
    logic       enable;
    logic       one_shot;
    logic [1:0] speed;
    logic [3:0] resolution;
    logic       running_average;
    logic       average_seed;
  } fmac_adc_cfg_type;

  // Conversion states of the converter: idle and busy.
  typedef enum { FMAC_CONV_IDLE, FMAC_CONV_BUSY } fmac_conv_state_type;

endpackage

// ===== verification/fmac_regs_sva.sv
// Port checker for the fault mask and ADC control bank.
`timescale 1ns/1ps
`default_nettype none
module fmac_regs_chk
  import fmac_pkg::*;
(
  // Clock, resets and register access.
  input wire logic             mclk_i,
  input wire logic             reset_n_i,
  input wire logic             reg_reset_i,
  input wire logic             watchdog_reset_i,
  input wire fmac_reg_req_type reg_req_i,
  input wire logic [7:0]       reg_rdata_o,
  input wire logic             reg_hit_o,
  // Conversion-done event and the observed outputs.
  input wire logic             adc_done_i,
  input wire logic             adc_done_irq_block_i,
  input wire fmac_adc_cfg_type adc_cfg_o,
  input wire logic             irq_pulse_o,
  input wire logic [12:0]      fault_event_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!reset_n_i);
  // Upper six data bits of the last request, for the write comparison.
  logic [5:0] wd_q;
  always_ff @(posedge mclk_i) begin
    wd_q <= reg_req_i.wdata[7:2];
  end
  a_irq_no_cause: assert property (fault_event_o == 13'h0 && !adc_done_i |=> !irq_pulse_o)
    else $error("interrupt without an event");
  a_done_cont_quiet: assert property (adc_done_i && !adc_cfg_o.one_shot && fault_event_o == 13'h0 |=> !irq_pulse_o)
    else $error("done interrupt in continuous mode");
  a_done_fires: assert property (adc_done_i && !adc_done_irq_block_i && adc_cfg_o.enable && adc_cfg_o.one_shot
    |=> irq_pulse_o)
    else $error("one-shot done gave no interrupt");
  a_done_blocked: assert property (adc_done_i && adc_done_irq_block_i && fault_event_o == 13'h0 |=> !irq_pulse_o)
    else $error("blocked done interrupt fired");
  a_res_decode: assert property (adc_cfg_o.resolution == FMAC_RES_BASE - {2'b00, adc_cfg_o.speed})
    else $error("resolution does not follow speed");
  a_wdog_clear_en: assert property (watchdog_reset_i |=> !adc_cfg_o.enable)
    else $error("watchdog left the ADC enabled");
  a_rst_cfg_vals: assert property (reg_reset_i |=> !adc_cfg_o.enable && !adc_cfg_o.one_shot && adc_cfg_o.speed == 2'b11
    && !adc_cfg_o.running_average && !adc_cfg_o.average_seed)
    else $error("register reset missed ADC control");
  a_ctrl_wr_fields: assert property (reg_req_i.wr && reg_req_i.addr == FMAC_OFS_ADC_CTRL && !reg_reset_i
    && !watchdog_reset_i |=> {adc_cfg_o.enable, adc_cfg_o.one_shot, adc_cfg_o.speed, adc_cfg_o.running_average,
    adc_cfg_o.average_seed} == wd_q)
    else $error("ADC control write not applied");
  a_maskb_rsvd_zero: assert property (reg_req_i.rd && reg_req_i.addr == FMAC_OFS_MASK_B |=> reg_rdata_o[1:0] == 2'b00)
    else $error("reserved mask bits read nonzero");
  a_hit_decode: assert property (reg_hit_o == ((reg_req_i.rd || reg_req_i.wr) && (reg_req_i.addr == FMAC_OFS_MASK_A
    || reg_req_i.addr == FMAC_OFS_MASK_B || reg_req_i.addr == FMAC_OFS_ADC_CTRL)))
    else $error("register hit flag wrong");
  c_irq: cover property (irq_pulse_o);
  c_done_shot: cover property (adc_done_i && adc_cfg_o.one_shot);
  c_wdog: cover property (watchdog_reset_i);
endmodule
bind fmac_regs fmac_regs_chk u_chk (.mclk_i, .reset_n_i, .reg_reset_i, .watchdog_reset_i, .reg_req_i, .reg_rdata_o,
  .reg_hit_o,
  .adc_done_i, .adc_done_irq_block_i, .adc_cfg_o, .irq_pulse_o, .fault_event_o);
`default_nettype wire

// ===== verification/fmac_host.sv
// Host model that issues one-cycle register strobes to the bank.
`timescale 1ns/1ps
`default_nettype none
module fmac_host
  import fmac_pkg::*;
(
  input  wire logic           mclk_i,
  input  wire logic [7:0]     reg_rdata_i,
  output var fmac_reg_req_type req_o
);
  // The bus idles with no strobe and a parked address.
  initial req_o = '0;
  // A write is launched after an edge and taken at the next one.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    #1 req_o = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge mclk_i);
    #1 req_o = '0;
  endtask
  // Read data stands only one cycle, so it is taken right after the strobe edge.
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk_i);
    #1 req_o = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge mclk_i);
    #1 req_o = '0;
    d = reg_rdata_i;
  endtask
endmodule
`default_nettype wire

// ===== verification/tb_top.sv
// Self-checking bench for the fault mask and ADC control bank.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import fmac_pkg::*;
  logic mclk_i = 1'b0, reset_n_i = 1'b0, reg_reset_i = 1'b0, watchdog_reset_i = 1'b0;
  logic adc_done_i = 1'b0, adc_done_irq_block_i = 1'b0, irq;
  logic [12:0] ev = '0, evo, blk;
  logic [7:0] rdata, rv;
  fmac_reg_req_type req;
  fmac_adc_cfg_type cfg;
  int bad_count = 0, n_tests = 0, ma, mb, ac = 'h30;
  initial forever #50 mclk_i = ~mclk_i;
  fmac_regs uut (.mclk_i, .reset_n_i, .reg_reset_i, .watchdog_reset_i, .reg_req_i(req), .reg_rdata_o(rdata),
    .reg_hit_o(), .batt_cur_reg_change_i(ev[12]), .in_bus_ovp_enter_i(ev[11]), .batt_ovp_enter_i(ev[10]),
    .in_ocp_fault_i(ev[9]), .batt_ocp_fault_i(ev[8]), .conv_ocp_fault_i(ev[7]), .in2_ovp_enter_i(ev[6]),
    .in1_ovp_enter_i(ev[5]), .sys_short_fault_i(ev[4]), .sys_ovp_fault_i(ev[3]), .rev_ovp_fault_i(ev[2]),
    .rev_uvp_fault_i(ev[1]), .tshut_event_i(ev[0]), .adc_done_i, .adc_done_irq_block_i, .adc_cfg_o(cfg),
    .irq_pulse_o(irq), .fault_event_o(evo));
  fmac_host host (.mclk_i, .reg_rdata_i(rdata), .req_o(req));
  // Compare one value and count it.
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    host.rd(a, rv);
    chk(rv, e);
  endtask
  task automatic results;
    if (bad_count == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // A hang costs far more than the few hundred cycles the tests need.
  initial begin
    #2000000;
    bad_count++;
    results;
  end
  initial begin
    void'($urandom(32'h867B));
    repeat (4) @(posedge mclk_i);
    #1 reset_n_i = 1'b1;
    rchk(FMAC_OFS_MASK_A, 8'h00);
    rchk(FMAC_OFS_MASK_B, 8'h00);
    rchk(FMAC_OFS_ADC_CTRL, 8'h30);
    rchk(8'h2F, 8'h00);
    // Masks go all clear, all set, then random; control walks every mode and speed.
    for (int i = 0; i < 16; i++) begin
      ma = (i == 0) ? 0 : (i == 1) ? 'hFF : $urandom & 'hFF;
      mb = (i == 0) ? 0 : (i == 1) ? 'hFF : $urandom & 'hFF;
      ac = (i << 4) | ($urandom & 'hF);
      host.wr(FMAC_OFS_MASK_A, ma[7:0]);
      host.wr(FMAC_OFS_MASK_B, mb[7:0]);
      host.wr(FMAC_OFS_ADC_CTRL, ac[7:0]);
      mb = mb & 'hFC;
      blk = {ma[7:0], mb[7:4], mb[2]};
      rchk(FMAC_OFS_MASK_A, ma[7:0]);
      rchk(FMAC_OFS_MASK_B, mb[7:0]);
      rchk(FMAC_OFS_ADC_CTRL, ac[7:0]);
      chk(cfg, {ac[7:4], 4'(15 - ac[5:4]), ac[3:2]});
      for (int j = 0; j < 13; j++) begin
        @(posedge mclk_i);
        #1 ev = 13'h1 << j;
        #10 chk(evo, ev);
        @(posedge mclk_i);
        #1 ev = '0;
        chk(irq, !blk[j]);
      end
      @(posedge mclk_i);
      #1 adc_done_i = 1'b1;
      adc_done_irq_block_i = i[0] ^ i[1];
      @(posedge mclk_i);
      #1 adc_done_i = 1'b0;
      chk(irq, ac[7] & ac[6] & !(i[0] ^ i[1]));
    end
    host.wr(FMAC_OFS_ADC_CTRL, 8'hFF);
    @(posedge mclk_i);
    #1 watchdog_reset_i = 1'b1;
    @(posedge mclk_i);
    #1 watchdog_reset_i = 1'b0;
    rchk(FMAC_OFS_ADC_CTRL, 8'h7F);
    @(posedge mclk_i);
    #1 reg_reset_i = 1'b1;
    @(posedge mclk_i);
    #1 reg_reset_i = 1'b0;
    rchk(FMAC_OFS_MASK_A, 8'h00);
    rchk(FMAC_OFS_ADC_CTRL, 8'h30);
    results;
  end
endmodule
`default_nettype wire
